// file: src/dpsc_stall_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module dpsc_stall_ctrl #(
  parameter int WORDS = dpsc_pkg::FETCH_WORDS,
  parameter int BANK_W = dpsc_pkg::BANK_W
) (
  // Clock, reset and clock enable.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Program side: fetching wanted, chaining bits of the group in the receive stage, memory ready.
  input wire logic fetch_run_in,
  input wire logic [WORDS-1:0] fetch_chain_bits_in,
  input wire logic fetch_mem_ready_in,
  // No-operation count of the group in the dispatch stage, and branch entering execute.
  input wire logic [dpsc_pkg::NOP_CNT_W-1:0] dispatch_nop_count_in,
  input wire logic branch_issue_in,
  // Interrupt taken: flushes the front of the pipeline.
  input wire logic irq_flush_in,
  // Loads of the group in decode, two lanes.
  input wire logic load_req_a_in,
  input wire logic [BANK_W-1:0] load_bank_a_in,
  input wire logic load_space_a_in,
  input wire logic load_req_b_in,
  input wire logic [BANK_W-1:0] load_bank_b_in,
  input wire logic load_space_b_in,
  input wire logic data_mem_ready_in,
  // Stall indications.
  output logic pipe_hold_out,
  output logic dispatch_stall_out,
  output logic mem_stall_out,
  output logic bank_stall_out,
  output logic nop_idle_out,
  output logic nop_cancel_out,
  // Stage occupancy and the group now in decode.
  output logic fetch_start_out,
  output logic [dpsc_pkg::FETCH_STAGES-1:0] fetch_stage_out,
  output logic decode_valid_out,
  output logic [WORDS-1:0] decode_mask_out,
  output logic [dpsc_pkg::LOAD_STAGES-1:0] load_stage_out
);

  localparam int IDX_W = dpsc_pkg::WORD_IDX_W;
  localparam int CW = dpsc_pkg::NOP_CNT_W;

  // State registers.
  dpsc_pkg::dpsc_disp_state_t state_reg;
  dpsc_pkg::dpsc_disp_state_t state_next;
  logic [dpsc_pkg::FETCH_STAGES-1:0] fetch_valid_reg;
  logic dp_valid_reg;
  logic [WORDS-1:0] dp_bits_reg;
  logic [IDX_W-1:0] dp_start_reg;
  logic [CW-1:0] nop_cnt_reg;
  logic [CW-1:0] nop_cnt_next;
  logic [CW-1:0] br_cnt_reg;
  logic mem_wait_reg;
  logic bank_hold_reg;
  logic bank_done_reg;
  logic disp_stall_reg;
  logic hold_reg;
  logic cancel_reg;
  logic start_reg;
  logic dc_valid_reg;
  logic [WORDS-1:0] dc_mask_reg;
  logic [dpsc_pkg::LOAD_STAGES-1:0] load_valid_reg;
  logic [dpsc_pkg::LOAD_LANES-1:0] lane_req_reg [0:2];
  logic [2*BANK_W-1:0] lane_bank_reg [0:2];
  logic [dpsc_pkg::LOAD_LANES-1:0] lane_space_reg [0:2];

  // Dispatch group decode of the fetch group held in the dispatch stage.
  wire logic [WORDS-1:0] grp_mask;
  wire logic [IDX_W-1:0] grp_end;
  wire logic grp_last;

  dpsc_group_scan #(
    .WORDS(WORDS),
    .IDX_W(IDX_W)
  ) u_scan (
    .chain_bits_in(dp_bits_reg),
    .start_in(dp_start_reg),
    .member_mask_out(grp_mask),
    .end_out(grp_end),
    .last_out(grp_last)
  );

  // Same-bank detection on the pair of loads in execute stage three.
  wire logic bank_conflict;

  dpsc_bank_check #(
    .BANK_W(BANK_W)
  ) u_bank (
    .req_a_in(lane_req_reg[dpsc_pkg::LOAD_MEM_STAGE][0]),
    .bank_a_in(lane_bank_reg[dpsc_pkg::LOAD_MEM_STAGE][BANK_W-1:0]),
    .space_a_in(lane_space_reg[dpsc_pkg::LOAD_MEM_STAGE][0]),
    .req_b_in(lane_req_reg[dpsc_pkg::LOAD_MEM_STAGE][1]),
    .bank_b_in(lane_bank_reg[dpsc_pkg::LOAD_MEM_STAGE][2*BANK_W-1:BANK_W]),
    .space_b_in(lane_space_reg[dpsc_pkg::LOAD_MEM_STAGE][1]),
    .conflict_out(bank_conflict)
  );

  // Advance conditions: memory stalls freeze every stage, idle and split freeze the front.
  wire logic in_idle = state_reg[dpsc_pkg::IDLE_BIT];
  wire logic exec_adv = !mem_wait_reg && !bank_hold_reg;
  wire logic dp_done = !dp_valid_reg || grp_last;
  wire logic front_ready = !in_idle && dp_done;
  wire logic fetch_adv = exec_adv && front_ready && !irq_flush_in;
  wire logic dp_fire = exec_adv && dp_valid_reg && !in_idle && !irq_flush_in;
  wire logic split_next = dp_fire && !grp_last;
  wire logic nop_load = dp_fire && (dispatch_nop_count_in > dpsc_pkg::NOP_SINGLE);
  wire logic br_done = exec_adv && (br_cnt_reg == CW'(1));
  wire logic nop_cut = br_done && in_idle;
  wire logic nop_end = exec_adv && in_idle && (nop_cnt_reg == CW'(1));
  wire logic load_mem_busy = load_valid_reg[dpsc_pkg::LOAD_MEM_STAGE];

  // Stall decisions for the next cycle.
  wire logic fetch_wait = fetch_valid_reg[dpsc_pkg::FETCH_MEM_STAGE] && front_ready
                          && !fetch_mem_ready_in;
  wire logic load_wait = load_mem_busy && !data_mem_ready_in;
  wire logic mem_wait_next = fetch_wait || load_wait;
  wire logic bank_hold_next = bank_conflict && !bank_hold_reg && !bank_done_reg;
  wire logic disp_stall_next = irq_flush_in ? 1'b0 :
                               (exec_adv && !in_idle) ? split_next : disp_stall_reg;
  wire logic idle_next = state_next[dpsc_pkg::IDLE_BIT];
  wire logic hold_next = mem_wait_next || bank_hold_next || disp_stall_next
                         || idle_next;
  wire logic [IDX_W-1:0] next_start = grp_end + IDX_W'(1);

  // Dispatch sequencer: flowing, splitting a fetch group, or issuing no-operation idles.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dpsc_pkg::DPSC_FLOW, dpsc_pkg::DPSC_SPLIT:
      begin
        if (irq_flush_in)
          state_next = dpsc_pkg::DPSC_FLOW;
        else if (nop_load)
          state_next = dpsc_pkg::DPSC_IDLE;
        else if (split_next)
          state_next = dpsc_pkg::DPSC_SPLIT;
        else if (dp_fire)
          state_next = dpsc_pkg::DPSC_FLOW;
      end
      dpsc_pkg::DPSC_IDLE:
      begin
        if (irq_flush_in || nop_cut || nop_end)
          state_next = dpsc_pkg::DPSC_FLOW;
      end
      default:
        state_next = dpsc_pkg::DPSC_FLOW;
    endcase
  end

  // Idle count: loaded with count less one, cut short by a finished branch.
  always_comb
  begin
    nop_cnt_next = nop_cnt_reg;
    if (irq_flush_in || nop_cut)
      nop_cnt_next = dpsc_pkg::CNT_RESET;
    else if (nop_load)
      nop_cnt_next = dispatch_nop_count_in - dpsc_pkg::NOP_SINGLE;
    else if (exec_adv && in_idle)
      nop_cnt_next = nop_cnt_reg - CW'(1);
  end

  // Sequencer, idle count and branch delay-slot count.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= dpsc_pkg::DPSC_FLOW;
      nop_cnt_reg <= dpsc_pkg::CNT_RESET;
      br_cnt_reg <= dpsc_pkg::CNT_RESET;
    end
    else if (clk_en_in)
    begin
      state_reg <= state_next;
      nop_cnt_reg <= nop_cnt_next;
      if (exec_adv && branch_issue_in)
        br_cnt_reg <= dpsc_pkg::BRANCH_DELAY_SLOTS;
      else if (exec_adv && (br_cnt_reg != dpsc_pkg::CNT_RESET))
        br_cnt_reg <= br_cnt_reg - CW'(1);
    end
  end

  // Fetch stages shift one place whenever the front may advance.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      fetch_valid_reg <= '0;
    else if (clk_en_in)
    begin
      if (irq_flush_in)
        fetch_valid_reg <= '0;
      else if (fetch_adv)
        fetch_valid_reg <= {fetch_valid_reg[dpsc_pkg::FETCH_STAGES-2:0], fetch_run_in};
    end
  end

  // Dispatch stage: take a new fetch group or step to its next dispatch group.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dp_valid_reg <= 1'b0;
      dp_bits_reg <= dpsc_pkg::BITS_RESET;
      dp_start_reg <= '0;
    end
    else if (clk_en_in)
    begin
      if (irq_flush_in)
        dp_valid_reg <= 1'b0;
      else if (fetch_adv)
      begin
        dp_valid_reg <= fetch_valid_reg[dpsc_pkg::FETCH_STAGES-1];
        dp_bits_reg <= fetch_chain_bits_in;
        dp_start_reg <= '0;
      end
      else if (split_next)
        dp_start_reg <= next_start;
    end
  end

  // Load lanes carry request, bank and space from execute stage one to three.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      load_valid_reg <= '0;
      for (int s = 0; s < 3; s++)
      begin
        lane_req_reg[s] <= '0;
        lane_bank_reg[s] <= '0;
        lane_space_reg[s] <= '0;
      end
    end
    else if (clk_en_in && exec_adv)
    begin
      load_valid_reg <= {load_valid_reg[dpsc_pkg::LOAD_STAGES-2:0],
                         load_req_a_in || load_req_b_in};
      lane_req_reg[0] <= {load_req_b_in, load_req_a_in};
      lane_bank_reg[0] <= {load_bank_b_in, load_bank_a_in};
      lane_space_reg[0] <= {load_space_b_in, load_space_a_in};
      for (int s = 1; s < 3; s++)
      begin
        lane_req_reg[s] <= lane_req_reg[s-1];
        lane_bank_reg[s] <= lane_bank_reg[s-1];
        lane_space_reg[s] <= lane_space_reg[s-1];
      end
    end
  end

  // Memory wait and bank-hit stalls; a bank hit holds for exactly one cycle.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mem_wait_reg <= 1'b0;
      bank_hold_reg <= 1'b0;
      bank_done_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      mem_wait_reg <= mem_wait_next;
      bank_hold_reg <= bank_hold_next;
      if (bank_hold_reg)
        bank_done_reg <= 1'b1;
      else if (exec_adv)
        bank_done_reg <= 1'b0;
    end
  end

  // Reported state: hold, dispatch stall, decode contents and fetch starts.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      disp_stall_reg <= 1'b0;
      hold_reg <= 1'b0;
      cancel_reg <= 1'b0;
      start_reg <= 1'b0;
      dc_valid_reg <= 1'b0;
      dc_mask_reg <= dpsc_pkg::BITS_RESET;
    end
    else if (clk_en_in)
    begin
      disp_stall_reg <= disp_stall_next;
      hold_reg <= hold_next;
      cancel_reg <= nop_cut;
      start_reg <= fetch_adv && fetch_run_in;
      dc_valid_reg <= dp_fire;
      dc_mask_reg <= dp_fire ? grp_mask : dpsc_pkg::BITS_RESET;
    end
  end

  // Outputs, each taken from a flip-flop.
  assign pipe_hold_out = hold_reg;
  assign dispatch_stall_out = disp_stall_reg;
  assign mem_stall_out = mem_wait_reg;
  assign bank_stall_out = bank_hold_reg;
  assign nop_idle_out = state_reg[dpsc_pkg::IDLE_BIT];
  assign nop_cancel_out = cancel_reg;
  assign fetch_start_out = start_reg;
  assign fetch_stage_out = fetch_valid_reg;
  assign decode_valid_out = dc_valid_reg;
  assign decode_mask_out = dc_mask_reg;
  assign load_stage_out = load_valid_reg;

endmodule // dpsc_stall_ctrl

`default_nettype wire

// file: src/dpsc_pkg.sv
package dpsc_pkg;

  // Shape of a fetch group and of its dispatch-group pointer.
  localparam int FETCH_WORDS = 8;
  localparam int WORD_IDX_W = 3;

  // Fetch stages, held as one valid bit each, first fetch stage in bit zero.
  localparam int FETCH_STAGES = 4;
  localparam int FETCH_MEM_STAGE = 2;

  // Load stages, execute stage one in bit zero; execute stage three does the access.
  localparam int LOAD_STAGES = 5;
  localparam int LOAD_LANES = 2;
  localparam int LOAD_MEM_STAGE = 2;
  localparam int BANK_W = 3;

  // Multicycle no-operation count and branch delay slots.
  localparam int NOP_CNT_W = 4;
  localparam logic [3:0] NOP_SINGLE = 4'h1;
  localparam logic [3:0] BRANCH_DELAY_SLOTS = 4'h5;

  // Reset values of the control state.
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [7:0] BITS_RESET = 8'h00;

  // Position of the idle state's code bit.
  localparam int IDLE_BIT = 2;

  // Dispatch sequencer states.
  typedef enum logic [2:0] {
    DPSC_FLOW = 3'h1,
    DPSC_SPLIT = 3'h2,
    DPSC_IDLE = 3'h4
  } dpsc_disp_state_t;

endpackage

// file: src/dpsc_group_scan.sv
`timescale 1ns/100ps
`default_nettype none

// Finds the dispatch group that starts at a given word of a fetch group.
module dpsc_group_scan #(
  parameter int WORDS = dpsc_pkg::FETCH_WORDS,
  parameter int IDX_W = dpsc_pkg::WORD_IDX_W
) (
  // Chaining bits of the fetch group and first word of the group.
  input wire logic [WORDS-1:0] chain_bits_in,
  input wire logic [IDX_W-1:0] start_in,
  // Members, last word and whether this group closes the fetch group.
  output logic [WORDS-1:0] member_mask_out,
  output logic [IDX_W-1:0] end_out,
  output logic last_out
);

  // A group ends at the first word whose chaining bit is clear; the final word always ends it.
  function automatic logic [IDX_W-1:0] find_end(input logic [WORDS-1:0] bits,
                                                input logic [IDX_W-1:0] start);
    logic found;
    logic [IDX_W-1:0] e;
    found = 1'b0;
    e = IDX_W'(WORDS - 1);
    for (int i = 0; i < WORDS - 1; i++)
    begin
      if (!found && (i >= int'(start)) && !bits[i])
      begin
        e = IDX_W'(i);
        found = 1'b1;
      end
    end
    return e;
  endfunction

  // Marks every word from the start word up to the end word.
  function automatic logic [WORDS-1:0] span_mask(input logic [IDX_W-1:0] start,
                                                 input logic [IDX_W-1:0] stop);
    logic [WORDS-1:0] m;
    m = '0;
    for (int i = 0; i < WORDS; i++)
    begin
      m[i] = (i >= int'(start)) && (i <= int'(stop));
    end
    return m;
  endfunction

  // Group decode from the chaining bits.
  assign end_out = find_end(chain_bits_in, start_in);
  assign member_mask_out = span_mask(start_in, end_out);
  assign last_out = (end_out == IDX_W'(WORDS - 1));

endmodule // dpsc_group_scan

`default_nettype wire

// file: src/dpsc_bank_check.sv
`timescale 1ns/100ps
`default_nettype none

// Flags two data accesses that meet in one single-ported bank of one memory space.
module dpsc_bank_check #(
  parameter int BANK_W = dpsc_pkg::BANK_W
) (
  // First access.
  input wire logic req_a_in,
  input wire logic [BANK_W-1:0] bank_a_in,
  input wire logic space_a_in,
  // Second access.
  input wire logic req_b_in,
  input wire logic [BANK_W-1:0] bank_b_in,
  input wire logic space_b_in,
  // Both accesses hit the same bank.
  output logic conflict_out
);

  // Different banks, or the same bank in another space, pass freely.
  wire logic same_bank = (bank_a_in == bank_b_in) && (space_a_in == space_b_in);
  assign conflict_out = req_a_in && req_b_in && same_bank;

endmodule // dpsc_bank_check

`default_nettype wire

// file: sim/dpsc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// Program and data memory as seen from the stall control, each answering on its own line.
module dpsc_mem_model (
  // Clock, reset and slow-mode commands from the bench.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_prog_in,
  input wire logic slow_data_in,
  // Stage occupancy of the fetch and load pipes.
  input wire logic [3:0] fetch_stage_in,
  input wire logic [4:0] load_stage_in,
  // Ready answers.
  output logic fetch_mem_ready_out,
  output logic data_mem_ready_out
);
  logic prog_wait_reg;
  logic data_wait_reg;

  // A slow space answers an access only after one wait cycle in its access stage.
  assign fetch_mem_ready_out = !(slow_prog_in && fetch_stage_in[2] && !prog_wait_reg);
  assign data_mem_ready_out = !(slow_data_in && load_stage_in[2] && !data_wait_reg);

  // Remembers that the access in the access stage has already waited once.
  always_ff @(posedge clk_in)
  begin
    prog_wait_reg <= !rst_in && fetch_stage_in[2];
    data_wait_reg <= !rst_in && load_stage_in[2];
  end
endmodule // dpsc_mem_model

`default_nettype wire

// file: sim/dpsc_stall_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the stall outputs against their causes at the ports.
module dpsc_stall_ctrl_chk #(
  parameter int WORDS = 8,
  parameter int BANK_W = 3
) (
  // Clock and control inputs.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic fetch_run_in,
  input wire logic fetch_mem_ready_in,
  input wire logic branch_issue_in,
  input wire logic irq_flush_in,
  input wire logic data_mem_ready_in,
  // Outputs under watch.
  input wire logic pipe_hold_out,
  input wire logic dispatch_stall_out,
  input wire logic mem_stall_out,
  input wire logic bank_stall_out,
  input wire logic nop_idle_out,
  input wire logic nop_cancel_out,
  input wire logic fetch_start_out,
  input wire logic [dpsc_pkg::FETCH_STAGES-1:0] fetch_stage_out,
  input wire logic decode_valid_out,
  input wire logic [WORDS-1:0] decode_mask_out,
  input wire logic [dpsc_pkg::LOAD_STAGES-1:0] load_stage_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Each stall cause and its reporting.
  hold_merge_a: assert property (pipe_hold_out == (dispatch_stall_out | mem_stall_out
    | bank_stall_out | nop_idle_out)) else $error("hold differs from stall sum");
  bank_single_a: assert property (bank_stall_out |=> !bank_stall_out)
    else $error("bank stall longer than one cycle");
  bank_cause_a: assert property (bank_stall_out |-> $past(load_stage_out[2]))
    else $error("bank stall without access stage load");
  mem_cause_a: assert property (mem_stall_out |-> $past(!data_mem_ready_in && load_stage_out[2]
    || !fetch_mem_ready_in && fetch_stage_out[2])) else $error("memory stall without slow memory");
  fetch_cause_a: assert property (fetch_start_out |-> $past(fetch_run_in))
    else $error("fetch started without request");
  split_step_a: assert property (dispatch_stall_out && !nop_idle_out |=> decode_valid_out
    || mem_stall_out || bank_stall_out) else $error("split stall without next group");
  split_hold_a: assert property (dispatch_stall_out && $past(dispatch_stall_out) |-> !fetch_start_out)
    else $error("fetch started during split");
  idle_hold_a: assert property (nop_idle_out && $past(nop_idle_out) |-> !fetch_start_out
    && !decode_valid_out) else $error("work started during idles");
  cancel_cause_a: assert property (nop_cancel_out |-> $past(branch_issue_in, 6) && !nop_idle_out)
    else $error("cancel not six cycles after branch");
  flush_clear_a: assert property (irq_flush_in |=> fetch_stage_out == '0 && !nop_idle_out)
    else $error("flush left front busy");
  mask_valid_a: assert property (decode_mask_out != '0 |-> decode_valid_out)
    else $error("mask shown without group");
endmodule // dpsc_stall_ctrl_chk

bind dpsc_stall_ctrl dpsc_stall_ctrl_chk #(.WORDS(WORDS), .BANK_W(BANK_W)) i_chk (.*);

`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// Drives fetch groups, no-ops, branches and loads, and scores decoded groups from a queue.
module tb_top;
  logic clk_in = 0, rst_in = 1, clk_en_in = 1, fetch_run_in = 0, branch_issue_in = 0;
  logic irq_flush_in = 0, load_req_a_in = 0, load_req_b_in = 0, load_space_a_in = 0;
  logic load_space_b_in = 0, slow_prog = 0, slow_data = 0, fetch_mem_ready_in, data_mem_ready_in;
  logic [7:0] fetch_chain_bits_in = 8'h00, decode_mask_out;
  logic [3:0] dispatch_nop_count_in = 4'h0, fetch_stage_out;
  logic [2:0] load_bank_a_in = 3'h0, load_bank_b_in = 3'h0, b;
  logic [4:0] load_stage_out;
  logic pipe_hold_out, dispatch_stall_out, mem_stall_out, bank_stall_out, nop_idle_out;
  logic nop_cancel_out, fetch_start_out, decode_valid_out;
  logic [7:0] exp_q[$];
  logic [7:0] chains[4] = '{8'h00, 8'h7F, 8'hFF, 8'h1B};
  integer seed = 32'h78fb8cde;
  int err_count = 0, n_compared = 0, n_disp, n_mem, n_bank, n_idle, g;

  dpsc_stall_ctrl i_dut (.*);
  dpsc_mem_model i_mem (.clk_in(clk_in), .rst_in(rst_in), .slow_prog_in(slow_prog),
    .slow_data_in(slow_data), .fetch_stage_in(fetch_stage_out), .load_stage_in(load_stage_out),
    .fetch_mem_ready_out(fetch_mem_ready_in), .data_mem_ready_out(data_mem_ready_in));

  // Free-running clock.
  initial
  begin
    forever #25 clk_in = !clk_in;
  end

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  // Notes the member mask of each dispatch group of one fetch group.
  function automatic void push_masks(input logic [7:0] c, output int groups);
    logic [7:0] m;
    m = 8'h00;
    groups = 0;
    for (int i = 0; i < 8; i++)
    begin
      m[i] = 1'b1;
      if (!c[i] || i == 7)
      begin
        exp_q.push_back(m);
        m = 8'h00;
        groups++;
      end
    end
  endfunction

  // Waits, bounded, until every noted group was decoded, then lets stalls drain.
  task automatic settle();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 300)
    begin
      tick();
      k++;
    end
    if (k == 300)
    begin
      err_count++;
      $display("mismatch at %0t: groups never decoded", $time);
      stop_test();
    end
    repeat (12) tick();
  endtask

  // Starts reps back-to-back fetch groups with one chaining pattern and no-op count.
  task automatic run_group(input logic [7:0] chain, input int reps, input logic [3:0] nop);
    n_disp = 0;
    n_mem = 0;
    n_idle = 0;
    fetch_chain_bits_in = chain;
    dispatch_nop_count_in = nop;
    fetch_run_in = 1;
    for (int r = 0; r < reps; r++)
    begin
      push_masks(chain, g);
      tick();
    end
    fetch_run_in = 0;
    settle();
    dispatch_nop_count_in = 4'h0;
  endtask

  // Issues one load pair for a single cycle and counts the bank stalls that follow.
  task automatic load_pair(input logic rb, input logic [2:0] ba, input logic [2:0] bb,
                           input logic sb, input int exp);
    n_bank = 0;
    n_mem = 0;
    load_req_a_in = 1;
    load_req_b_in = rb;
    load_bank_a_in = ba;
    load_bank_b_in = bb;
    load_space_b_in = sb;
    tick();
    load_req_a_in = 0;
    load_req_b_in = 0;
    repeat (12) tick();
    check(8'(n_bank), 8'(exp), "bank stall cycles");
  endtask

  // Scores each decoded group against the oldest note and counts stall cycles.
  always @(posedge clk_in)
  begin
    #2;
    n_disp += int'(dispatch_stall_out);
    n_mem += int'(mem_stall_out);
    n_bank += int'(bank_stall_out);
    n_idle += int'(nop_idle_out);
    if (!rst_in && decode_valid_out === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        err_count++;
        $display("mismatch at %0t: unexpected dispatch group", $time);
      end
      else
        check(decode_mask_out, exp_q.pop_front(), "group members");
    end
  end

  // Main sequence.
  initial
  begin
    repeat (10) tick();
    rst_in = 0;
    tick();
    for (int i = 0; i < 10; i++)
    begin
      run_group(i < 4 ? chains[i] : 8'($random(seed)), 2, 4'h0);
      check(8'(n_disp), 8'(2 * (g - 1)), "split stall cycles");
    end
    for (int n = 0; n < 8; n++)
    begin
      run_group(8'h7F, 1, 4'(n));
      check(8'(n_idle), 8'(n > 1 ? n - 1 : 0), "idle cycles");
    end
    run_group(8'h7F, 0, 4'h0);
    fetch_run_in = 1;
    dispatch_nop_count_in = 4'h8;
    push_masks(8'h7F, g);
    tick();
    fetch_run_in = 0;
    for (int k = 0; k < 20 && nop_idle_out !== 1'b1; k++) tick();
    branch_issue_in = 1;
    tick();
    branch_issue_in = 0;
    repeat (5) tick();
    check({nop_cancel_out, nop_idle_out}, 8'h02, "cancel at sixth cycle");
    settle();
    check(8'(n_idle), 8'h06, "idle cycles cut by branch");
    dispatch_nop_count_in = 4'h0;
    slow_prog = 1;
    run_group(8'h7F, 1, 4'h0);
    check(8'(n_mem), 8'h01, "fetch wait cycles");
    slow_prog = 0;
    slow_data = 1;
    load_pair(0, 3'h2, 3'h2, 0, 0);
    check(8'(n_mem), 8'h01, "load wait cycles");
    slow_data = 0;
    b = 3'($random(seed));
    load_pair(1, b, b, 0, 1);
    load_pair(1, b, b, 1, 0);
    load_pair(1, b, b + 3'h1, 0, 0);
    fetch_run_in = 1;
    tick();
    fetch_run_in = 0;
    tick();
    irq_flush_in = 1;
    tick();
    irq_flush_in = 0;
    check(8'(fetch_stage_out), 8'h00, "fetch stages after flush");
    repeat (12) tick();
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
